// *** psram_burst_pkg.sv ***
/*
 * Shared constants, carrier types and the group-size decode for the burst
 * address sequencer of the pseudo-static memory.
 * Assumes a single 100 MHz clock domain and word (16-bit) addressing.
 */
`default_nettype none

package psram_burst_pkg;

    // Word address width of the array (4 Mwords).
    localparam int ADDR_W = 22;

    // Depth of the address FIFO in front of the array access logic.
    localparam int FIFO_DEPTH = 8;

    // Burst length field codes, named by their length in bytes.
    localparam logic [1:0] LEN_128B = 2'h0;
    localparam logic [1:0] LEN_64B  = 2'h1;
    localparam logic [1:0] LEN_16B  = 2'h2;
    localparam logic [1:0] LEN_32B  = 2'h3;

    // Word masks for each group size: 64, 32, 8 and 16 words.
    localparam logic [ADDR_W-1:0] MASK_128B = 22'h00003F;
    localparam logic [ADDR_W-1:0] MASK_64B  = 22'h00001F;
    localparam logic [ADDR_W-1:0] MASK_16B  = 22'h000007;
    localparam logic [ADDR_W-1:0] MASK_32B  = 22'h00000F;

    // Value of the sequence code after reset: legacy wrap over 32 bytes.
    localparam logic       HYBRID_RESET = 1'h1;
    localparam logic [1:0] LEN_RESET    = LEN_32B;

    // Number of synchroniser stages on the chip select pin.
    localparam int SYNC_STAGES = 3;

    // Burst sequence code: hybrid-enable bit above the length field.
    typedef struct packed {
        logic       hybrid_enable_bit;
        logic [1:0] len;
    } burst_sequence_code_type;

    // Command taken from the command-address phase.
    typedef struct packed {
        logic              burst_type_cmd_bit;
        logic [ADDR_W-1:0] addr;
    } burst_cmd_type;

    // Group mask for a burst length code.
    function automatic logic [ADDR_W-1:0] group_mask(input logic [1:0] len);
        logic [ADDR_W-1:0] m;
        m = MASK_32B;
        unique case (len)
            LEN_128B: m = MASK_128B;
            LEN_64B:  m = MASK_64B;
            LEN_16B:  m = MASK_16B;
            LEN_32B:  m = MASK_32B;
        endcase
        return m;
    endfunction

endpackage

`default_nettype wire

// *** psram_burst_address_sequencer.sv ***
/*
 * Burst address sequencer with its output FIFO. Turns the start word
 * address of a burst into the order of word addresses for the array.
 * Assumes the command decoder gives a one-cycle start pulse on mclk_i,
 * that chip select comes straight from the pin, and that the array side
 * drains addresses with a valid/ready handshake.
 */
`timescale 1ns/1ps
`default_nettype none

// Small synchronous FIFO; data out comes from the storage flip-flops.
module addr_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             mclk_i,
    input  wire logic             srst_i,
    input  wire logic             flush_i,
    // Fill side.
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side.
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [PW:0]      next_count;
    logic             push;
    logic             pop;
    // Full and empty follow the occupancy count directly.
    assign in_ready_o  = (count != DEPTH[PW:0]);
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    // Pointer and count update; a flush drops everything queued.
    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (flush_i)
        begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count  = '0;
        end
        else
        begin
            if (push)
                next_wr_ptr = PW'(wr_ptr + 1'b1);
            if (pop)
                next_rd_ptr = PW'(rd_ptr + 1'b1);
            if (push && !pop)
                next_count = count + 1'b1;
            else if (pop && !push)
                next_count = count - 1'b1;
        end
    end
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end
    // Storage needs no reset; nothing reads a slot before it is written.
    always_ff @(posedge mclk_i)
    begin
        if (push && !flush_i)
            mem[wr_ptr] <= in_data_i;
    end

endmodule // addr_fifo

// Overview of operation
// - A legacy wrapped burst keeps every word inside one group aligned to its own length.
// - Group sizes of 16, 32, 64 and 128 bytes are supported, aligned to their length.
// - A wrap runs from the start word to the group end, back to the group start, and up to the word before the start.
// - A hybrid burst wraps once and then goes to the first word of the next group.
// - After the first wrap a hybrid burst counts up linearly until chip select goes high.
// - The hybrid-enable bit resets to one for legacy wrap, and zero selects hybrid sequencing.
// - With a wrapped command, code 000 gives hybrid over 128 bytes and 001 hybrid over 64 bytes.
// - With a wrapped command, code 010 gives hybrid over 16 bytes and 011 hybrid over 32 bytes.
// - Addresses count 16-bit words, so a 16-byte group is eight words.
// - A 64-byte hybrid burst from word 2E covers 2E to 3F, 20 to 2D, then runs on from 40.
// - Length codes 00, 01, 10, 11 mean 128, 64, 16, 32 bytes, with 32 bytes after reset.
module psram_burst_address_sequencer
(
    // Clock and reset.
    input  wire logic                                     mclk_i,
    input  wire logic                                     srst_i,
    // Sequence code load.
    input  wire logic                                     cfg_wr_i,
    input  wire psram_burst_pkg::burst_sequence_code_type cfg_i,
    output psram_burst_pkg::burst_sequence_code_type      cfg_o,
    // Burst command from the command-address phase.
    input  wire logic                                     start_i,
    input  wire psram_burst_pkg::burst_cmd_type           cmd_i,
    // Chip select pin, active low.
    input  wire logic                                     cs_n_i,
    // Word address stream to the array.
    output logic                                          addr_valid_o,
    input  wire logic                                     addr_ready_i,
    output logic [psram_burst_pkg::ADDR_W-1:0]            addr_o,
    // Burst status.
    output logic                                          busy_o
);
    import psram_burst_pkg::*;
    typedef enum logic [1:0] {
        IDLE = 2'b01,
        RUN  = 2'b10
    } seq_state_type;
    seq_state_type           state;
    seq_state_type           next_state;
    burst_sequence_code_type cfg_q;
    burst_sequence_code_type next_cfg_q;
    logic [ADDR_W-1:0]       cur;
    logic [ADDR_W-1:0]       next_cur;
    logic [ADDR_W-1:0]       start_q;
    logic [ADDR_W-1:0]       next_start_q;
    logic [ADDR_W-1:0]       mask_q;
    logic [ADDR_W-1:0]       next_mask_q;
    logic                    linear_q;
    logic                    next_linear_q;
    logic                    hybrid_q;
    logic                    next_hybrid_q;
    logic                    done_q;
    logic                    next_done_q;
    logic [SYNC_STAGES-1:0]  cs_sync;
    logic                    cs_high;
    logic                    cs_low;
    logic                    take;
    logic                    push;
    logic                    fifo_ready;
    logic                    wrapping;
    logic [ADDR_W-1:0]       base;
    logic [ADDR_W-1:0]       inc_low;
    logic [ADDR_W-1:0]       step_addr;
    logic                    wrap_end;

    // Chip select crosses in from the pin; only stages two and three decide.
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            cs_sync <= '1;
        else
            cs_sync <= {cs_sync[SYNC_STAGES-2:0], cs_n_i};
    end
    assign cs_high = cs_sync[1] && cs_sync[2];
    assign cs_low  = !cs_sync[1] && !cs_sync[2];

    // Sequence code register; it is sampled only when a burst starts, so a
    // load during a burst cannot tear the running sequence.
    always_comb
    begin
        next_cfg_q = cfg_q;
        if (cfg_wr_i)
            next_cfg_q = cfg_i;
    end
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            cfg_q.hybrid_enable_bit <= HYBRID_RESET;
            cfg_q.len               <= LEN_RESET;
        end
        else
            cfg_q <= next_cfg_q;
    end
    assign cfg_o = cfg_q;

    // Address arithmetic for one step of the running burst.
    assign wrapping  = !linear_q && !done_q;
    assign base      = cur & ~mask_q;
    assign inc_low   = ADDR_W'(cur + 1'b1) & mask_q;
    assign wrap_end  = wrapping && hybrid_q
                       && (inc_low == (start_q & mask_q));
    assign step_addr = wrap_end ? ADDR_W'(base + mask_q + 1'b1)
                     : wrapping ? (base | inc_low)
                     : ADDR_W'(cur + 1'b1);
    assign take = (state == IDLE) && start_i && cs_low;
    assign push = (state == RUN) && !cs_high && fifo_ready;

    // Burst control: latch the mode at start, step once per free slot,
    // stop as soon as chip select is seen high.
    always_comb
    begin
        next_state    = state;
        next_cur      = cur;
        next_start_q  = start_q;
        next_mask_q   = mask_q;
        next_linear_q = linear_q;
        next_hybrid_q = hybrid_q;
        next_done_q   = done_q;
        unique case (state)
            IDLE:
            begin
                if (take)
                begin
                    next_state    = RUN;
                    next_cur      = cmd_i.addr;
                    next_start_q  = cmd_i.addr;
                    next_mask_q   = group_mask(cfg_q.len);
                    next_linear_q = cmd_i.burst_type_cmd_bit;
                    next_hybrid_q = !cfg_q.hybrid_enable_bit;
                    next_done_q   = 1'b0;
                end
            end
            RUN:
            begin
                if (cs_high)
                    next_state = IDLE;
                else if (push)
                begin
                    next_cur = step_addr;
                    if (wrap_end)
                        next_done_q = 1'b1;
                end
            end
        endcase
    end
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            state    <= IDLE;
            cur      <= '0;
            start_q  <= '0;
            mask_q   <= MASK_32B;
            linear_q <= 1'b0;
            hybrid_q <= 1'b0;
            done_q   <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            cur      <= next_cur;
            start_q  <= next_start_q;
            mask_q   <= next_mask_q;
            linear_q <= next_linear_q;
            hybrid_q <= next_hybrid_q;
            done_q   <= next_done_q;
        end
    end
    assign busy_o = (state == RUN);

    // Addresses left queued when the burst ends are stale and are dropped.
    addr_fifo #(
        .WIDTH (ADDR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .srst_i      (srst_i),
        .flush_i     (state == RUN && cs_high),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (cur),
        .out_valid_o (addr_valid_o),
        .out_ready_i (addr_ready_i),
        .out_data_o  (addr_o)
    );

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    property p_group;
        push && wrapping |-> ((cur & ~mask_q) == (start_q & ~mask_q));
    endproperty
    a_group: assert property (p_group)
        else $error("wrapped word left its group");
    property p_size;
        take ##1 1'b1 |-> (mask_q == 22'h7 && $past(cfg_q.len) == LEN_16B)
            || (mask_q == 22'hF && $past(cfg_q.len) == LEN_32B)
            || (mask_q == 22'h1F && $past(cfg_q.len) == LEN_64B)
            || (mask_q == 22'h3F && $past(cfg_q.len) == LEN_128B);
    endproperty
    a_size: assert property (p_size)
        else $error("group size does not match length code");
    property p_wrap_back;
        push && wrapping && !wrap_end && ((cur & mask_q) == mask_q)
            |=> ((cur & mask_q) == '0);
    endproperty
    a_wrap_back: assert property (p_wrap_back)
        else $error("wrap did not return to group start");
    property p_hybrid_jump;
        $rose(done_q) |-> (cur == ADDR_W'($past(base) + mask_q + 1'b1));
    endproperty
    a_hybrid_jump: assert property (p_hybrid_jump)
        else $error("hybrid burst did not enter next group");
    property p_linear;
        push && done_q |=> (cur == ADDR_W'($past(cur) + 1'b1));
    endproperty
    a_linear: assert property (p_linear)
        else $error("linear phase did not count up by one");
    property p_end;
        (state == RUN) && cs_high |=> (state == IDLE) && !addr_valid_o;
    endproperty
    a_end: assert property (p_end)
        else $error("burst did not stop on chip select high");
    property p_reset_cfg;
        $fell(srst_i) |-> (cfg_q.hybrid_enable_bit && cfg_q.len == LEN_32B);
    endproperty
    a_reset_cfg: assert property (p_reset_cfg)
        else $error("sequence code wrong after reset");
    property p_hybrid_sel;
        take && !cmd_i.burst_type_cmd_bit
            |=> (hybrid_q == !$past(cfg_q.hybrid_enable_bit)) && !linear_q;
    endproperty
    a_hybrid_sel: assert property (p_hybrid_sel)
        else $error("hybrid selection does not follow code");
    property p_step;
        (state == RUN) && !cs_high && fifo_ready
            |=> addr_valid_o && (cur != $past(cur));
    endproperty
    a_step: assert property (p_step)
        else $error("sequencer missed a step");

endmodule // psram_burst_address_sequencer

`default_nettype wire

// *** burst_host_model.sv ***
/*
 * Behavioural host controller for the burst sequencer bench: drives chip
 * select, the one-cycle start pulse and the burst command.
 * Assumes one clock and bench requests that change just after the edge.
 */
`timescale 1ns/1ps
`default_nettype none

module burst_host_model
(
    // Clock and reset.
    input  wire logic                           mclk_i,
    input  wire logic                           srst_i,
    // Requests from the bench.
    input  wire logic                           req_i,
    input  wire logic                           end_i,
    input  wire psram_burst_pkg::burst_cmd_type req_cmd_i,
    // Pins toward the device.
    output logic                                cs_n_o,
    output logic                                start_o,
    output psram_burst_pkg::burst_cmd_type      cmd_o
);
    import psram_burst_pkg::*;

    burst_cmd_type held;
    int            wait_cnt;

    initial
    begin
        cs_n_o   = 1'b1;
        start_o  = 1'b0;
        held     = '0;
        wait_cnt = 0;
    end

    // Outside the start cycle the command lines show the inverse of the
    // last command, so a stale value can never pass for a fresh one.
    assign cmd_o = start_o ? held : ~held;

    // Chip select goes low first and the start pulse waits until the
    // device synchroniser has seen it; a burst ends only by chip select.
    always @(posedge mclk_i)
    begin
        start_o <= #1 (!srst_i && !req_i && !end_i && wait_cnt == 1);
        if (srst_i)
        begin
            cs_n_o   <= #1 1'b1;
            wait_cnt <= 0;
        end
        else if (req_i)
        begin
            cs_n_o   <= #1 1'b0;
            held     <= #1 req_cmd_i;
            wait_cnt <= 5;
        end
        else if (end_i)
            cs_n_o <= #1 1'b1;
        else if (wait_cnt != 0)
            wait_cnt <= wait_cnt - 1;
    end

endmodule // burst_host_model

`default_nettype wire

// *** psram_burst_address_sequencer_tb.sv ***
/*
 * Self-checking bench for the burst address sequencer: a reference model
 * of the word order is compared with every address taken from the FIFO.
 * Assumes the host model in its own file and a 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module psram_burst_address_sequencer_tb;
    import psram_burst_pkg::*;

    logic                    mclk_i, srst_i, cfg_wr_i, addr_ready_i;
    logic                    req, fin, cs_n, start, active;
    burst_sequence_code_type cfg_i, cfg_o;
    burst_cmd_type           req_cmd, cmd;
    logic                    addr_valid_o, busy_o;
    logic [ADDR_W-1:0]       addr_o;
    int bad_count, cmp_count, n_seen, t_first, t_last, cyc;
    int s_cur, n_cur, lin_cur, hyb_cur, exp_addr;
    integer seed = 32'hf1a7df2e;
    int grp[4] = '{64, 32, 8, 16};

    psram_burst_address_sequencer dut (.mclk_i(mclk_i), .srst_i(srst_i),
        .cfg_wr_i(cfg_wr_i), .cfg_i(cfg_i), .cfg_o(cfg_o), .start_i(start),
        .cmd_i(cmd), .cs_n_i(cs_n), .addr_valid_o(addr_valid_o),
        .addr_ready_i(addr_ready_i), .addr_o(addr_o), .busy_o(busy_o));

    burst_host_model host (.mclk_i(mclk_i), .srst_i(srst_i), .req_i(req),
        .end_i(fin), .req_cmd_i(req_cmd), .cs_n_o(cs_n), .start_o(start),
        .cmd_o(cmd));

    // Clock of 10 ns.
    initial
    begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic compare(input string what, input logic [31:0] seen,
                           input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask

    // Reference word order: wrap inside the aligned group, then either
    // repeat the group (legacy) or run on linearly (hybrid).
    function automatic int exp_word(int s, int n, int hyb, int lin, int i);
        int b;
        b = s - (s % n);
        if (lin != 0)
            return s + i;
        if (hyb != 0 && i >= n)
            return b + i;
        return b + (s - b + i) % n;
    endfunction

    // Every address accepted by the consumer is checked against the model.
    always @(posedge mclk_i)
    begin
        if (active && addr_valid_o === 1'b1 && addr_ready_i === 1'b1)
        begin
            exp_addr = exp_word(s_cur, n_cur, hyb_cur, lin_cur, n_seen);
            compare("addr", {10'h0, addr_o}, exp_addr);
            if (n_seen == 0)
                t_first = cyc;
            t_last = cyc;
            n_seen++;
        end
        cyc++;
    end

    // One burst: load the code, start, drain, end by chip select high.
    task automatic run_burst(input int code, input int s, input int lin,
                             input int stall);
        int k;
        cfg_wr_i = 1'b1;
        cfg_i    = burst_sequence_code_type'(code[2:0]);
        tick();
        cfg_wr_i = 1'b0;
        compare("cfg", cfg_o, code[2:0]);
        s_cur   = s;
        n_cur   = grp[code[1:0]];
        hyb_cur = !code[2];
        lin_cur = lin;
        n_seen  = 0;
        active  = 1'b1;
        req_cmd = {lin[0], 22'(s)};
        req     = 1'b1;
        addr_ready_i = (stall == 0);
        tick();
        req = 1'b0;
        if (stall != 0)
        begin
            repeat (16) tick();
            compare("full", addr_valid_o, 1);
        end
        k = 0;
        while (n_seen < 2 * n_cur + 4 && k < 2000)
        begin
            if (stall != 0)
                addr_ready_i = $random(seed);
            tick();
            k++;
        end
        compare("count", n_seen >= 2 * n_cur + 4, 1);
        fin = 1'b1;
        tick();
        fin = 1'b0;
        k = 0;
        while (busy_o !== 1'b0 && k < 20)
        begin
            tick();
            k++;
        end
        compare("busy", busy_o, 0);
        tick();
        compare("drained", addr_valid_o, 0);
        if (stall == 0)
            compare("rate", t_last - t_first, n_seen - 1);
        active = 1'b0;
        addr_ready_i = 1'b0;
        $display("test done code %0h start %0h linear %0d", code, s, lin);
    endtask

    // Codes and starts of the table cases: hybrid, legacy, then linear.
    int codes[12]  = '{0, 1, 1, 2, 2, 3, 3, 4, 5, 6, 7, 6};
    int starts[12] = '{'h03, 'h03, 'h2E, 'h02, 'h0C, 'h0A, 'h1E, 'h03,
                       'h2E, 'h0C, 'h1E, 'h03};

    initial
    begin
        srst_i = 1'b1;
        cfg_wr_i = 1'b0;
        cfg_i = '0;
        addr_ready_i = 1'b0;
        req = 1'b0;
        fin = 1'b0;
        req_cmd = '0;
        active = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        n_seen = 0;
        cyc = 0;
        repeat (6) tick();
        srst_i = 1'b0;
        compare("cfg reset", cfg_o, 3'h7);
        for (int i = 0; i < 12; i++)
            run_burst(codes[i], starts[i], i == 11, i % 2);
        for (int i = 0; i < 4; i++)
            run_burst($random(seed) & 7, $random(seed) & 'hFFF,
                      $random(seed) & 1, i % 2);
        give_verdict();
    end

    // Watchdog well beyond the expected run of a few thousand cycles.
    initial
    begin
        #600000;
        bad_count++;
        give_verdict();
    end

endmodule // psram_burst_address_sequencer_tb

`default_nettype wire
